// ==== logic/seeb_pkg.sv ====
// Shared constants and types for the serial EEPROM bus slave
package seeb_pkg;

   // Clock and timing
   localparam int CLK_MHZ          = 100;
   localparam int PROG_TIME_MS     = 10;
   localparam int PROG_CYCLES_DFLT = PROG_TIME_MS * 1000 * CLK_MHZ;

   // Byte framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] TX_LAST_BIT   = 4'h7;
   localparam logic [3:0] RXACK_GOOD    = 4'h1;
   localparam logic [3:0] RXACK_NONE    = 4'h9;

   // Device address word layout
   localparam int DEVW_TYPE_LSB = 4;
   localparam int DEVW_SEL_LSB  = 1;
   localparam int DEVW_RW_BIT   = 0;

   // Page layout
   localparam int PAGE_OFS_W = 6;
   localparam int PAGE_BYTES = 64;
   localparam logic [2:0] PROT_TOP = 3'h7;

   // Two-entry buffer
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   typedef struct packed {
      logic       scl;
      logic       sda;
      logic       wp;
      logic [2:0] strap;
   } seeb_pins_s;

   localparam int PIN_W = $bits(seeb_pins_s);
   // Idle bus lines are high; straps and lock start low
   localparam logic [PIN_W-1:0] PINS_RST = 6'h30;

   typedef struct packed {
      logic [PAGE_OFS_W-1:0] ofs;
      logic [7:0]            data;
   } seeb_wr_item_s;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RXBYTE = 3'b001,
      ST_ACK    = 3'b010,
      ST_TXBYTE = 3'b011,
      ST_RXACK  = 3'b100
   } seeb_state_e;

   typedef enum logic [2:0] {
      PH_DEV  = 3'b000,
      PH_AHI  = 3'b001,
      PH_ALO  = 3'b010,
      PH_DATA = 3'b011,
      PH_RD   = 3'b100
   } seeb_phase_e;

endpackage

// ==== logic/seeb_mem.sv ====
// Single-port byte memory with registered read data
`timescale 1ns/1ps
module seeb_mem #(
   parameter int DATA_W = 8,
   parameter int DEPTH  = 64,
   parameter int AW     = 6
) (
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   input  wire logic              we_i,
   input  wire logic [AW-1:0]     addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   output logic      [DATA_W-1:0] rdata_o
);

   logic [DATA_W-1:0] mem [DEPTH];

   always_ff @(posedge mclk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   // Array contents are not reset; only the read register is
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem[addr_i];
      end
   end

endmodule

// ==== logic/seeb_bus_slave.sv ====
// Two-wire bus slave front end of a serial EEPROM with page programming
// How it works
// RULE1 - Sample data on clock rise, change outgoing data after clock fall.
// RULE2 - Master keeps the clock at or below 400 kHz.
// RULE3 - Data line is open drain: only pull low or release.
// RULE4 - Data changes only while clock low, except start and stop.
// RULE5 - Data falling while clock high is a start; transactions begin there.
// RULE6 - Data rising while clock high is a stop; ends a read to standby.
// RULE7 - Stop after written data launches the timed programming cycle.
// RULE8 - Bytes of eight bits, ninth clock carries receiver acknowledge.
// RULE9 - Acknowledge every written byte and the device word of reads.
// RULE10 - After read byte release; acknowledge sends next byte, otherwise end.
// RULE11 - Without acknowledge or stop, stay released and send nothing more.
// RULE12 - Device word: type code, three select bits, direction bit.
// RULE13 - Acknowledge only on type and strap match, else stay in standby.
// RULE14 - Up to eight devices, straps tied to distinct levels.
// RULE15 - Byte write: device word, two address bytes, one data byte.
// RULE16 - During programming ignore the bus except acknowledge polling.
// RULE17 - Up to 64 data bytes per cycle, low six address bits increment.
// RULE18 - Page offset wraps inside the page; later data overwrites.
// RULE19 - Write device word gets no acknowledge while programming runs.
// RULE20 - Lock pin high blocks writes to the upper eighth of the array.
// RULE21 - Reads work whatever the lock pin level.
// RULE22 - Lock pin must stay stable; it is sampled, not latched.
// RULE23 - Programming lasts at most the program cycle time after stop.
// RULE24 - Address counter holds last accessed address plus one.
// RULE25 - Only low address bits that fit the array are used.
// RULE26 - Locked writes are still acknowledged but change nothing.
`timescale 1ns/1ps
module seeb_bus_slave
   import seeb_pkg::*;
#(
   parameter int         ADDR_W      = 15,
   parameter int         PROG_CYCLES = PROG_CYCLES_DFLT,
   // Arbitrary value
   parameter logic [3:0] DEV_TYPE    = 4'h6
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic       wp_i,
   input  wire logic [2:0] select_strap_pins_i,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   output logic            busy_o
);

   localparam int CNT_W = $clog2(PROG_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);
   localparam logic [6:0] IDX_END = 7'(PAGE_BYTES);

   function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a,
                                                    input logic in_page);
      logic [ADDR_W-1:0] full;
      full = a + ADDR_W'(1);
      addr_step = in_page ? {a[ADDR_W-1:PAGE_OFS_W], full[PAGE_OFS_W-1:0]} : full;
   endfunction

   // Pin synchroniser: three stages, a level counts when stages two and three agree
   seeb_pins_s          pin_raw;
   logic [PIN_W-1:0]    s1_reg;
   logic [PIN_W-1:0]    s2_reg;
   logic [PIN_W-1:0]    s3_reg;
   logic [PIN_W-1:0]    flt_reg;
   logic [PIN_W-1:0]    flt_next;
   logic [PIN_W-1:0]    prv_reg;
   seeb_pins_s          cur;
   seeb_pins_s          prv;

   assign pin_raw  = '{scl: scl_i, sda: sda_i, wp: wp_i, strap: select_strap_pins_i};
   assign flt_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & flt_reg);
   assign cur      = seeb_pins_s'(flt_reg);
   assign prv      = seeb_pins_s'(prv_reg);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         s1_reg  <= PINS_RST;
         s2_reg  <= PINS_RST;
         s3_reg  <= PINS_RST;
         flt_reg <= PINS_RST;
         prv_reg <= PINS_RST;
      end else begin
         s1_reg  <= pin_raw;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         flt_reg <= flt_next;
         prv_reg <= flt_reg;
      end
   end

   wire scl_rise  = cur.scl & ~prv.scl;
   wire scl_fall  = ~cur.scl & prv.scl;
   wire start_det = cur.scl & prv.scl & prv.sda & ~cur.sda;  // see RULE5
   wire stop_det  = cur.scl & prv.scl & ~prv.sda & cur.sda;  // see RULE6

   // Bus state
   seeb_state_e         state_reg, state_next;
   seeb_phase_e         phase_reg, phase_next;
   logic [3:0]          bcnt_reg, bcnt_next;
   logic [7:0]          shr_reg, shr_next;
   logic [7:0]          ahi_reg, ahi_next;
   logic [7:0]          txd_reg, txd_next;
   logic                rw_reg, rw_next;
   logic                got_reg, got_next;
   logic                oe_n_reg, oe_n_next;
   logic [ADDR_W-1:0]   addr_reg, addr_next;
   logic                push;
   logic                prog_go;
   logic                ack_ok;
   logic                prog_busy_reg;

   wire dev_match = (shr_reg[7:DEVW_TYPE_LSB] == DEV_TYPE)
                  & (shr_reg[DEVW_TYPE_LSB-1:DEVW_SEL_LSB] == cur.strap);  // see RULE12

   // Two-entry buffer between the bus side and the page latch
   seeb_wr_item_s       buf_reg [2];
   logic                buf_wp_reg;
   logic                buf_rp_reg;
   logic [1:0]          buf_cnt_reg;
   seeb_wr_item_s       buf_in;
   wire                 buf_in_ready  = (buf_cnt_reg != BUF_DEPTH);
   wire                 buf_out_valid = (buf_cnt_reg != 2'h0);
   wire                 buf_out_ready = ~prog_busy_reg;
   wire                 buf_pop       = buf_out_valid & buf_out_ready;
   wire                 buf_push      = push & buf_in_ready;
   seeb_wr_item_s       buf_head;

   assign buf_in   = '{ofs: addr_reg[PAGE_OFS_W-1:0], data: shr_reg};
   assign buf_head = buf_reg[buf_rp_reg];

   always_comb begin
      case (phase_reg)
         PH_DEV:  ack_ok = dev_match & ~prog_busy_reg;  // see RULE13 RULE19 RULE16
         PH_DATA: ack_ok = buf_in_ready;                // see RULE26
         default: ack_ok = 1'b1;
      endcase
   end

   logic [7:0] arr_rdata;

   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      bcnt_next  = bcnt_reg;
      shr_next   = shr_reg;
      ahi_next   = ahi_reg;
      txd_next   = txd_reg;
      rw_next    = rw_reg;
      got_next   = got_reg;
      oe_n_next  = oe_n_reg;
      addr_next  = addr_reg;
      push       = 1'b0;
      prog_go    = 1'b0;
      if (start_det) begin
         state_next = ST_RXBYTE;
         phase_next = PH_DEV;
         bcnt_next  = 4'h0;
         oe_n_next  = 1'b1;
      end else if (stop_det) begin
         state_next = ST_IDLE;
         oe_n_next  = 1'b1;
         got_next   = 1'b0;
         prog_go    = got_reg & ~prog_busy_reg;  // see RULE7 RULE15
      end else begin
         case (state_reg)
            ST_RXBYTE: begin
               if (scl_rise) begin
                  shr_next  = {shr_reg[6:0], cur.sda};  // see RULE1
                  bcnt_next = bcnt_reg + 4'h1;
               end else if (scl_fall && bcnt_reg == BITS_PER_BYTE) begin
                  bcnt_next = 4'h0;
                  if (ack_ok) begin
                     state_next = ST_ACK;
                     oe_n_next  = 1'b0;  // see RULE8 RULE9 RULE3
                     case (phase_reg)
                        PH_DEV:  rw_next = shr_reg[DEVW_RW_BIT];
                        PH_AHI:  ahi_next = shr_reg;
                        PH_ALO:  addr_next = ADDR_W'({ahi_reg, shr_reg});  // see RULE25
                        PH_DATA: begin
                           push      = 1'b1;
                           got_next  = 1'b1;
                           addr_next = addr_step(addr_reg, 1'b1);  // see RULE17 RULE18
                        end
                        default: ;
                     endcase
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (phase_reg == PH_DEV && rw_reg) begin
                     state_next = ST_TXBYTE;
                     phase_next = PH_RD;
                     txd_next   = arr_rdata;
                     oe_n_next  = arr_rdata[7];  // see RULE21 RULE4
                  end else begin
                     state_next = ST_RXBYTE;
                     oe_n_next  = 1'b1;
                     case (phase_reg)
                        PH_DEV:  phase_next = PH_AHI;
                        PH_AHI:  phase_next = PH_ALO;
                        default: phase_next = PH_DATA;
                     endcase
                  end
               end
            end
            ST_TXBYTE: begin
               if (scl_rise) begin
                  bcnt_next = bcnt_reg + 4'h1;
                  if (bcnt_reg == TX_LAST_BIT) begin
                     addr_next = addr_step(addr_reg, 1'b0);  // see RULE24
                  end
               end else if (scl_fall) begin
                  if (bcnt_reg == BITS_PER_BYTE) begin
                     state_next = ST_RXACK;
                     bcnt_next  = 4'h0;
                     oe_n_next  = 1'b1;  // see RULE10
                  end else begin
                     txd_next  = {txd_reg[6:0], 1'b0};
                     oe_n_next = txd_reg[6];  // see RULE1 RULE4
                  end
               end
            end
            ST_RXACK: begin
               if (scl_rise) begin
                  bcnt_next = cur.sda ? RXACK_NONE : RXACK_GOOD;
               end else if (scl_fall) begin
                  if (bcnt_reg == RXACK_GOOD) begin
                     state_next = ST_TXBYTE;
                     bcnt_next  = 4'h0;
                     txd_next   = arr_rdata;
                     oe_n_next  = arr_rdata[7];  // see RULE10
                  end else if (bcnt_reg == RXACK_NONE) begin
                     // Line stays released until a new start
                     state_next = ST_IDLE;  // see RULE11
                  end
               end
            end
            ST_IDLE: ;
            default: state_next = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
         phase_reg <= PH_DEV;
         bcnt_reg  <= 4'h0;
         shr_reg   <= 8'h00;
         ahi_reg   <= 8'h00;
         txd_reg   <= 8'h00;
         rw_reg    <= 1'b0;
         got_reg   <= 1'b0;
         oe_n_reg  <= 1'b1;
         addr_reg  <= '0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         bcnt_reg  <= bcnt_next;
         shr_reg   <= shr_next;
         ahi_reg   <= ahi_next;
         txd_reg   <= txd_next;
         rw_reg    <= rw_next;
         got_reg   <= got_next;
         oe_n_reg  <= oe_n_next;
         addr_reg  <= addr_next;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         buf_wp_reg  <= 1'b0;
         buf_rp_reg  <= 1'b0;
         buf_cnt_reg <= 2'h0;
      end else begin
         if (buf_push) begin
            buf_reg[buf_wp_reg] <= buf_in;
            buf_wp_reg          <= ~buf_wp_reg;
         end
         if (buf_pop) begin
            buf_rp_reg <= ~buf_rp_reg;
         end
         buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // Programming cycle: copy loaded latch bytes into the array, then hold busy
   logic [CNT_W-1:0]            pcnt_reg;
   logic [6:0]                  idx_reg;
   logic                        cp_vld_reg;
   logic [PAGE_OFS_W-1:0]       cp_ofs_reg;
   logic [ADDR_W-PAGE_OFS_W-1:0] page_reg;
   logic [PAGE_BYTES-1:0]       mask_reg;
   logic [7:0]                  lat_rdata;

   wire                  copying  = prog_busy_reg & (idx_reg != IDX_END);
   wire [ADDR_W-1:0]     cp_addr  = {page_reg, cp_ofs_reg};
   wire                  locked   = cur.wp                                 // see RULE22
                                  & (cp_addr[ADDR_W-1 -: 3] == PROT_TOP);  // see RULE20
   wire                  arr_we   = cp_vld_reg & mask_reg[cp_ofs_reg] & ~locked;    // see RULE26
   wire [ADDR_W-1:0]     arr_addr = prog_busy_reg ? cp_addr : addr_reg;
   wire [PAGE_OFS_W-1:0] lat_addr = prog_busy_reg ? idx_reg[PAGE_OFS_W-1:0] : buf_head.ofs;
   wire                  prog_end = prog_busy_reg & (pcnt_reg == CNT_LAST);          // see RULE23

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         prog_busy_reg <= 1'b0;
         pcnt_reg      <= '0;
         idx_reg       <= 7'h00;
         cp_vld_reg    <= 1'b0;
         cp_ofs_reg    <= '0;
         page_reg      <= '0;
         mask_reg      <= '0;
      end else begin
         cp_vld_reg <= copying;
         cp_ofs_reg <= idx_reg[PAGE_OFS_W-1:0];
         if (prog_go) begin
            prog_busy_reg <= 1'b1;
            pcnt_reg      <= '0;
            idx_reg       <= 7'h00;
            page_reg      <= addr_reg[ADDR_W-1:PAGE_OFS_W];
         end else if (prog_end) begin
            prog_busy_reg <= 1'b0;  // see RULE7
            mask_reg      <= '0;
         end else if (prog_busy_reg) begin
            pcnt_reg <= pcnt_reg + CNT_W'(1);
            if (copying) begin
               idx_reg <= idx_reg + 7'h01;
            end
         end
         if (buf_pop) begin
            mask_reg[buf_head.ofs] <= 1'b1;  // see RULE18
         end
      end
   end

   seeb_mem #(
      .DATA_W (8),
      .DEPTH  (1 << ADDR_W),
      .AW     (ADDR_W)
   ) u_array (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .we_i    (arr_we),
      .addr_i  (arr_addr),
      .wdata_i (lat_rdata),
      .rdata_o (arr_rdata)
   );

   seeb_mem #(
      .DATA_W (8),
      .DEPTH  (PAGE_BYTES),
      .AW     (PAGE_OFS_W)
   ) u_page_latch (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .we_i    (buf_pop),
      .addr_i  (lat_addr),
      .wdata_i (buf_head.data),
      .rdata_o (lat_rdata)
   );

   // Output register stage; the pad only ever pulls low
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sda_o      <= 1'b0;
         sda_oe_n_o <= 1'b1;
         busy_o     <= 1'b0;
      end else begin
         sda_o      <= 1'b0;  // see RULE3
         sda_oe_n_o <= oe_n_reg;
         busy_o     <= prog_busy_reg;
      end
   end

endmodule

// ==== tb/seeb_bus_checker.sv ====
// Port-level assertions for the two-wire EEPROM bus slave
`timescale 1ns/1ps
module seeb_bus_checker #(
   parameter int PROG_CYCLES = 200
) (
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       wp_i,
   input wire logic [2:0] select_strap_pins_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_n_o,
   input wire logic       busy_o
);
   int   busy_cnt_reg;
   int   stop_age_reg;
   logic sda_q_reg;
   // Stop age saturates so a long idle spell cannot wrap into a false recent stop
   always_ff @(posedge mclk_i) begin
      sda_q_reg <= sda_i;
      if (!rst_n_i) begin
         busy_cnt_reg <= 0;
         stop_age_reg <= 99;
      end else begin
         busy_cnt_reg <= busy_o ? busy_cnt_reg + 1 : 0;
         stop_age_reg <= (scl_i && sda_i && !sda_q_reg) ? 0 :
                         (stop_age_reg < 99 ? stop_age_reg + 1 : 99);
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_stop;
      scl_i && !sda_i ##1 scl_i && sda_i;
   endsequence
   sequence s_released;
      sda_oe_n_o [*4];
   endsequence
   property p_reset_idle;
      $rose(rst_n_i) |-> sda_oe_n_o && !busy_o;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs busy at reset exit");
   property p_open_drain;
      sda_o == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("data driven high");
   property p_change_scl_low;
      $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 3);
   endproperty
   a_change_scl_low: assert property (p_change_scl_low)
      else $error("data moved with clock high");
   property p_ack_stands;
      $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8];
   endproperty
   a_ack_stands: assert property (p_ack_stands)
      else $error("low bit too short");
   property p_busy_quiet;
      busy_o |-> sda_oe_n_o;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("line pulled while busy");
   property p_busy_after_stop;
      $rose(busy_o) |-> stop_age_reg <= 12;
   endproperty
   a_busy_after_stop: assert property (p_busy_after_stop)
      else $error("busy without stop");
   property p_busy_len;
      $fell(busy_o) |-> busy_cnt_reg >= PROG_CYCLES - 2 && busy_cnt_reg <= PROG_CYCLES + 2;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("program time wrong");
   property p_stop_release;
      s_stop |=> s_released;
   endproperty
   a_stop_release: assert property (p_stop_release)
      else $error("line held after stop");
endmodule
bind seeb_bus_slave seeb_bus_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .wp_i(wp_i),
   .select_strap_pins_i(select_strap_pins_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
   .busy_o(busy_o));

// ==== tb/seeb_bus_master.sv ====
// Behavioural two-wire bus master driving the clock and sharing the data line
`timescale 1ns/1ps
module seeb_bus_master (
   input  wire logic mclk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_n_o
);
   // Quarter of a 160 ns bus clock period, far faster than the 400 kHz top bus rate
   localparam int QTR = 4;
   initial begin
      scl_o = 1'b1;
      sda_oe_n_o = 1'b1;
   end
   task automatic wait_q(input int n);
      repeat (n * QTR) @(negedge mclk_i);
   endtask
   // Serves as first or repeated start; clock stands high only while idle
   task automatic start();
      if (!scl_o) begin
         wait_q(1);
         sda_oe_n_o = 1'b1;
         wait_q(1);
         scl_o = 1'b1;
      end
      wait_q(2);
      sda_oe_n_o = 1'b0;
      wait_q(2);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      wait_q(1);
      sda_oe_n_o = 1'b0;
      wait_q(1);
      scl_o = 1'b1;
      wait_q(2);
      sda_oe_n_o = 1'b1;
      wait_q(2);
   endtask
   // Eight bits MSB first, then the acknowledge slot; ninth=1 releases the line
   task automatic xfer(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
                       output logic ack);
      logic [8:0] bits;
      bits = {tx, ninth};
      for (int i = 8; i >= 0; i--) begin
         wait_q(1);
         sda_oe_n_o = bits[i];
         wait_q(1);
         scl_o = 1'b1;
         wait_q(1);
         if (i > 0) rx[i-1] = sda_i;
         else ack = sda_i;
         wait_q(1);
         scl_o = 1'b0;
      end
   endtask
endmodule

// ==== tb/seeb_bus_slave_tb.sv ====
// Self-checking bench for the two-wire EEPROM bus slave
`timescale 1ns/1ps
module seeb_bus_slave_tb;
   import seeb_pkg::*;
   localparam int         PROG  = 200;
   localparam logic [3:0] TCODE = 4'h6; // Arbitrary type code
   localparam logic [2:0] STRAP = 3'h5;
   logic       mclk_i  = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       wp_i    = 1'b0;
   logic [2:0] strap   = STRAP;
   logic       scl;
   logic       m_oe_n;
   logic       sda;
   logic       sda_o;
   logic       sda_oe_n_o;
   logic       busy_o;
   int         failures = 0;
   int         n_tests  = 0;
   assign sda = (!m_oe_n || !sda_oe_n_o) ? 1'b0 : 1'b1;
   always #5 mclk_i = ~mclk_i;
   seeb_bus_slave #(.PROG_CYCLES(PROG), .DEV_TYPE(TCODE)) DUT (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .wp_i(wp_i),
      .select_strap_pins_i(strap), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o));
   seeb_bus_master mst (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic dev(input logic [7:0] w, output logic ack);
      logic [7:0] q;
      mst.start();
      mst.xfer(w, 1'b1, q, ack);
   endtask
   task automatic wbyte(input logic [7:0] d);
      logic [7:0] q;
      logic       ack;
      mst.xfer(d, 1'b1, q, ack);
      check("byte ack", ack, 1'b0);
   endtask
   task automatic set_addr(input logic [15:0] a);
      logic ack;
      dev({TCODE, STRAP, 1'b0}, ack);
      check("write word ack", ack, 1'b0);
      wbyte(a[15:8]);
      wbyte(a[7:0]);
   endtask
   // Bound covers the full program time plus slack
   task automatic wait_idle();
      for (int i = 0; i < PROG + 50 && busy_o !== 1'b0; i++) @(negedge mclk_i);
      if (busy_o !== 1'b0) begin
         failures++;
         end_sim();
      end
   endtask
   task automatic write(input logic [15:0] a, input logic [7:0] d[$]);
      set_addr(a);
      foreach (d[i]) wbyte(d[i]);
      mst.stop();
      check("busy after stop", busy_o, 1'b1);
      wait_idle();
   endtask
   task automatic read(input logic [15:0] a, input int n, output logic [7:0] q[$]);
      logic       ack;
      logic [7:0] b;
      q = {};
      set_addr(a);
      dev({TCODE, STRAP, 1'b1}, ack);
      check("read word ack", ack, 1'b0);
      for (int i = 0; i < n; i++) begin
         mst.xfer(8'hff, i == n - 1, b, ack);
         q.push_back(b);
      end
      mst.stop();
   endtask
   task automatic t_select();
      logic ack;
      for (int s = 0; s < 9; s++) begin
         dev(s < 8 ? {TCODE, s[2:0], 1'b0} : {~TCODE, STRAP, 1'b0}, ack);
         check("select ack", ack, s == STRAP ? 1'b0 : 1'b1);
         mst.stop();
      end
      check("no program on empty write", busy_o, 1'b0);
      // Moving the straps must move the address the device answers to
      strap = 3'h2;
      dev({TCODE, 3'h2, 1'b0}, ack);
      check("moved strap ack", ack, 1'b0);
      mst.stop();
      dev({TCODE, STRAP, 1'b0}, ack);
      check("old strap ack", ack, 1'b1);
      mst.stop();
      strap = STRAP;
      $display("t_select done");
   endtask
   task automatic t_byte_poll();
      logic       ack;
      logic [7:0] q[$];
      set_addr(16'h8123);
      wbyte(8'ha5);
      mst.stop();
      check("busy after stop", busy_o, 1'b1);
      dev({TCODE, STRAP, 1'b0}, ack);
      check("poll while busy", ack, 1'b1);
      mst.stop();
      wait_idle();
      dev({TCODE, STRAP, 1'b0}, ack);
      check("poll when done", ack, 1'b0);
      mst.stop();
      read(16'h0123, 1, q);
      check("byte write", q[0], 8'ha5);
      $display("t_byte_poll done");
   endtask
   // 66 bytes from offset 3E: the last two overwrite the first two
   task automatic t_page();
      logic [7:0] d[$];
      logic [7:0] q[$];
      logic [7:0] b;
      logic       ack;
      for (int k = 0; k < 66; k++) d.push_back(8'h80 + k[7:0]);
      write(16'h00fe, d);
      dev({TCODE, STRAP, 1'b1}, ack);
      mst.xfer(8'hff, 1'b1, b, ack);
      mst.stop();
      check("counter after write", b, 8'h82);
      read(16'h00c0, 64, q);
      foreach (q[o]) check("page byte", q[o], 8'h82 + o[7:0]);
      $display("t_page done");
   endtask
   task automatic t_nack_hold();
      logic       ack;
      logic [7:0] b;
      set_addr(16'h00c0);
      dev({TCODE, STRAP, 1'b1}, ack);
      mst.xfer(8'hff, 1'b1, b, ack);
      check("read byte", b, 8'h82);
      mst.xfer(8'hff, 1'b1, b, ack);
      check("released after nack", b, 8'hff);
      mst.stop();
      $display("t_nack_hold done");
   endtask
   // Lock level only changes between operations
   task automatic t_lock();
      logic [7:0] q[$];
      write(16'h7ff0, {8'h5a});
      wp_i = 1'b1;
      write(16'h7ff0, {8'h3c});
      write(16'h5ff0, {8'h3c});
      read(16'h7ff0, 1, q);
      check("locked byte", q[0], 8'h5a);
      read(16'h5ff0, 1, q);
      check("open byte", q[0], 8'h3c);
      wp_i = 1'b0;
      $display("t_lock done");
   endtask
   initial begin
      repeat (6) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (10) @(negedge mclk_i);
      t_select();
      t_byte_poll();
      t_page();
      t_nack_hold();
      t_lock();
      end_sim();
   end
endmodule
